// [verilog/sees_defines.vh]
// constants for the serial eeprom slave front end
`ifndef SEES_DEFINES_VH
`define SEES_DEFINES_VH

// control byte layout
`define SEES_CTRL_CODE    4'hA
`define SEES_CODE_HI      7
`define SEES_CODE_LO      4
`define SEES_BLOCK_BIT    3
`define SEES_CSEL_HI_BIT  2
`define SEES_CSEL_LO_BIT  1
`define SEES_RW_BIT       0

// bit slot counts within one byte frame
`define SEES_ACK_SLOT     4'h8
`define SEES_ACK_DONE     4'h9

// page buffer
`define SEES_PAGE_BYTES   128
`define SEES_PAGE_LAST    7'h7F

// write cycle time: 5 ms counted in 50 MHz system clocks
`define SEES_TWC_CYC      18'h3D090

// programming stream word: address 17 bits, data 8 bits
`define SEES_PROG_W       25

`endif

// [verilog/sees_fifo2.v]
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns

module sees_fifo2 #(
   parameter WIDTH = 25
) (
   // clock and reset
   input  wire             clk_sys,
   input  wire             sys_rst,
   // filling side
   input  wire             inValid,
   output wire             inReady,
   input  wire [WIDTH-1:0] inData,
   // draining side
   output wire             outValid,
   input  wire             outReady,
   output wire [WIDTH-1:0] outData
);

   reg [WIDTH-1:0] mem_q [0:1];
   reg             wrPtr_q;
   reg             rdPtr_q;
   reg [1:0]       cnt_q;

   wire            push;
   wire            pop;

   // full and empty come straight from the count
   assign inReady  = (cnt_q != 2'h2);
   assign outValid = (cnt_q != 2'h0);
   assign outData  = mem_q[rdPtr_q];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   // pointers and count; push and pop may share a cycle
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wrPtr_q <= 1'b0;
         rdPtr_q <= 1'b0;
         cnt_q   <= 2'h0;
      end else begin
         if (push)
            wrPtr_q <= ~wrPtr_q;
         if (pop)
            rdPtr_q <= ~rdPtr_q;
         if (push & ~pop)
            cnt_q <= cnt_q + 2'h1;
         else if (pop & ~push)
            cnt_q <= cnt_q - 2'h1;
      end
   end

   // storage written at the write pointer
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mem_q[0] <= {WIDTH{1'b0}};
         mem_q[1] <= {WIDTH{1'b0}};
      end else if (push) begin
         mem_q[wrPtr_q] <= inData;
      end
   end

endmodule

// [verilog/sees_slave.v]
// two-wire eeprom slave: protocol engine, page buffer, write cycle
`timescale 1ns/1ns
`include "sees_defines.vh"

module sees_slave #(
   parameter [17:0] TWC_CYCLES = `SEES_TWC_CYC
) (
   // clock and reset
   input  wire        clk_sys,
   input  wire        sys_rst,
   // two-wire bus pins
   input  wire        sclIn,
   input  wire        sdaIn,
   output wire        sdaOut,
   output wire        sdaOe,
   // chip address and protect pins
   input  wire        chipSelPinLow,
   input  wire        chipSelPinHigh,
   input  wire        fixedSelectPin,
   input  wire        writeProtect,
   // status
   output wire        writeBusy,
   // array read port, data valid in the same cycle
   output wire [16:0] memRdAddr,
   input  wire [7:0]  memRdData,
   // array programming stream
   output wire        memWrValid,
   input  wire        memWrReady,
   output wire [16:0] memWrAddr,
   output wire [7:0]  memWrData
);

   // ==========================================================
   // declarations
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_CTRL  = 3'h1;
   localparam [2:0] ST_ADRH  = 3'h2;
   localparam [2:0] ST_ADRL  = 3'h3;
   localparam [2:0] ST_WDATA = 3'h4;
   localparam [2:0] ST_RDATA = 3'h5;

   reg  [5:0]  syncM_q;
   reg  [5:0]  syncS_q;
   reg         sclP_q;
   reg         sdaP_q;
   reg  [2:0]  state_q;
   reg  [2:0]  nxt_q;
   reg  [3:0]  bitCnt_q;
   reg  [7:0]  sh_q;
   reg  [7:0]  tx_q;
   reg  [16:0] ptr_q;
   reg         wrote_q;
   reg         sdaOe_q;
   reg         busy_q;
   reg  [17:0] timer_q;
   reg  [9:0]  base_q;
   reg  [6:0]  idx_q;
   reg         streamDone_q;

   wire        sclS;
   wire        sdaS;
   wire        cselLo;
   wire        cselHi;
   wire        fixSel;
   wire        wpS;
   wire        sclRise;
   wire        sclFall;
   wire        startDet;
   wire        stopDet;
   wire        match;
   wire        decide;
   wire        ctrlWrAck;
   wire        pbWr;
   wire        progGo;
   wire        wpSkip;
   wire        busyEnd;
   wire        clrLoaded;
   wire [127:0] ldVec;
   wire [7:0]  pbByte [0:127];
   wire        bufInValid;
   wire        bufInReady;
   wire [24:0] bufInData;
   wire [24:0] bufOutData;
   wire [7:0]  progByte;

   // ==========================================================
   // pin synchronisers and bus condition detection
   // every pin passes two flops; edges are seen on stage two
   // select and protect pins share the stages so all move together
   // the two clocks of latency are far below one link bit
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         syncM_q <= 6'h3F;
         syncS_q <= 6'h3F;
         sclP_q  <= 1'b1;
         sdaP_q  <= 1'b1;
      end else begin
         syncM_q <= {sclIn, sdaIn, chipSelPinLow, chipSelPinHigh,
                     fixedSelectPin, writeProtect};
         syncS_q <= syncM_q;
         sclP_q  <= syncS_q[5];
         sdaP_q  <= syncS_q[4];
      end
   end

   assign sclS    = syncS_q[5];
   assign sdaS    = syncS_q[4];
   assign cselLo  = syncS_q[3];
   assign cselHi  = syncS_q[2];
   assign fixSel  = syncS_q[1];
   assign wpS     = syncS_q[0];
   assign sclRise = sclS & ~sclP_q;
   assign sclFall = ~sclS & sclP_q;
   // sda moving while scl stays high marks start or stop
   assign startDet = sclS & sclP_q & sdaP_q & ~sdaS;
   assign stopDet  = sclS & sclP_q & ~sdaP_q & sdaS;

   // ==========================================================
   // control byte match and one-cycle events
   // any control byte is refused while busy, polling included
   // refusing every byte, not only the polling one, keeps reads
   // off the read port while it serves the page readback
   assign match = (sh_q[`SEES_CODE_HI:`SEES_CODE_LO] == `SEES_CTRL_CODE)
                & (sh_q[`SEES_CSEL_HI_BIT] == cselHi)
                & (sh_q[`SEES_CSEL_LO_BIT] == cselLo)
                & fixSel & ~busy_q;
   assign decide    = sclFall & (bitCnt_q == `SEES_ACK_SLOT);
   assign ctrlWrAck = decide & (state_q == ST_CTRL) & match
                    & ~sh_q[`SEES_RW_BIT];
   assign pbWr      = decide & (state_q == ST_WDATA);
   assign progGo    = stopDet & (state_q == ST_WDATA) & wrote_q
                    & ~wpS;
   assign wpSkip    = stopDet & (state_q == ST_WDATA) & wrote_q
                    & wpS;
   assign busyEnd   = busy_q & (timer_q == 18'h0) & streamDone_q
                    & ~memWrValid;
   assign clrLoaded = ctrlWrAck | wpSkip | busyEnd;

   // ==========================================================
   // protocol engine
   // a start or stop outranks any clock edge seen in the same cycle
   // sdaOe is the only bus output that moves; it changes after scl falls, or clears on a start or stop
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_q    <= ST_IDLE;
         nxt_q      <= ST_IDLE;
         bitCnt_q   <= 4'h0;
         sh_q       <= 8'h00;
         tx_q       <= 8'h00;
         ptr_q      <= 17'h00000;
         wrote_q    <= 1'b0;
         sdaOe_q    <= 1'b0;
      end else if (startDet) begin
         // a start abandons whatever was in flight
         state_q  <= ST_CTRL;
         bitCnt_q <= 4'h0;
         sdaOe_q  <= 1'b0;
      end else if (stopDet) begin
         state_q <= ST_IDLE;
         sdaOe_q <= 1'b0;
      end else if (state_q != ST_IDLE) begin
         if (sclRise) begin
            // data is taken while scl is high
            if (bitCnt_q < `SEES_ACK_SLOT) begin
               sh_q     <= {sh_q[6:0], sdaS};
               bitCnt_q <= bitCnt_q + 4'h1;
            end else if (bitCnt_q == `SEES_ACK_SLOT) begin
               bitCnt_q <= `SEES_ACK_DONE;
               if ((state_q == ST_RDATA) & sdaS) begin
                  state_q <= ST_IDLE;
               end
            end
         end else if (sclFall) begin
            if (bitCnt_q == `SEES_ACK_DONE) begin
               // leave the ack slot; reads load the next byte here
               bitCnt_q <= 4'h0;
               state_q  <= nxt_q;
               sdaOe_q  <= 1'b0;
               if (nxt_q == ST_RDATA) begin
                  tx_q    <= memRdData;
                  sdaOe_q <= ~memRdData[7];
                  ptr_q[15:0] <= ptr_q[15:0] + 16'h0001;
               end
            end else if (bitCnt_q == `SEES_ACK_SLOT) begin
               case (state_q)
                  ST_CTRL: begin
                     if (match) begin
                        sdaOe_q    <= 1'b1;
                        ptr_q[16]  <= sh_q[`SEES_BLOCK_BIT];
                        wrote_q    <= 1'b0;
                        nxt_q <= sh_q[`SEES_RW_BIT] ? ST_RDATA
                                                    : ST_ADRH;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end
                  ST_ADRH: begin
                     sdaOe_q     <= 1'b1;
                     ptr_q[15:8] <= sh_q;
                     nxt_q       <= ST_ADRL;
                  end
                  ST_ADRL: begin
                     sdaOe_q    <= 1'b1;
                     ptr_q[7:0] <= sh_q;
                     nxt_q      <= ST_WDATA;
                  end
                  ST_WDATA: begin
                     // only the page offset steps, so a run wraps
                     sdaOe_q    <= 1'b1;
                     ptr_q[6:0] <= ptr_q[6:0] + 7'h01;
                     wrote_q    <= 1'b1;
                     nxt_q      <= ST_WDATA;
                  end
                  ST_RDATA: begin
                     sdaOe_q <= 1'b0; // master owns the ack slot
                  end
                  default: begin
                     state_q <= ST_IDLE;
                  end
               endcase
            end else if (state_q == ST_RDATA) begin
               // next bit goes out while scl is low
               sdaOe_q <= ~tx_q[3'h7 - bitCnt_q[2:0]];
            end
         end
      end
   end

   // ==========================================================
   // page buffer: one byte and one loaded flag per entry
   // flags mark bytes taken this command; the rest come from the array
   // flops cost area but let any entry be written in one cycle
   genvar gi;
   generate
      for (gi = 0; gi < `SEES_PAGE_BYTES; gi = gi + 1) begin : gPage
         localparam [31:0] IDXW = gi;
         reg [7:0] byte_q;
         reg       ld_q;
         always @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
               byte_q <= 8'h00;
               ld_q   <= 1'b0;
            end else if (pbWr & (ptr_q[6:0] == IDXW[6:0])) begin
               byte_q <= sh_q;
               ld_q   <= 1'b1;
            end else if (clrLoaded) begin
               ld_q <= 1'b0;
            end
         end
         assign pbByte[gi] = byte_q;
         assign ldVec[gi]  = ld_q;
      end
   endgenerate

   // ==========================================================
   // write cycle: stream the whole page, then hold busy
   // untouched bytes are read back so the full page is rewritten
   // busy holds until the buffer drains, so a stalled array can
   // stretch the cycle beyond the nominal write time
   assign progByte   = ldVec[idx_q] ? pbByte[idx_q] : memRdData;
   assign memRdAddr  = busy_q ? {base_q, idx_q} : ptr_q;
   assign bufInValid = busy_q & ~streamDone_q;
   assign bufInData  = {base_q, idx_q, progByte};

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         busy_q       <= 1'b0;
         timer_q      <= 18'h00000;
         base_q       <= 10'h000;
         idx_q        <= 7'h00;
         streamDone_q <= 1'b1;
      end else if (progGo) begin
         busy_q       <= 1'b1;
         timer_q      <= TWC_CYCLES - 18'h00001;
         base_q       <= ptr_q[16:7];
         idx_q        <= 7'h00;
         streamDone_q <= 1'b0;
      end else if (busy_q) begin
         if (timer_q != 18'h00000)
            timer_q <= timer_q - 18'h00001;
         if (bufInValid & bufInReady) begin
            idx_q <= idx_q + 7'h01;
            if (idx_q == `SEES_PAGE_LAST)
               streamDone_q <= 1'b1;
         end
         if (busyEnd)
            busy_q <= 1'b0;
      end
   end

   // ==========================================================
   // buffer in the programming path; a stalled array stalls the stream
   sees_fifo2 #(
      .WIDTH    (`SEES_PROG_W)
   ) uBuf (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .inValid  (bufInValid),
      .inReady  (bufInReady),
      .inData   (bufInData),
      .outValid (memWrValid),
      .outReady (memWrReady),
      .outData  (bufOutData)
   );

   // ==========================================================
   // outputs
   assign memWrAddr = bufOutData[24:8];
   assign memWrData = bufOutData[7:0];
   assign sdaOut    = 1'b0;          // open drain: only ever pulls low
   assign sdaOe     = sdaOe_q;
   assign writeBusy = busy_q;

endmodule

// [testbench/sees_slave_monitor.sv]
// concurrent checks on the eeprom slave ports
`timescale 1ns/1ns

module sees_slave_monitor (
   // clock and reset
   input wire        clk_sys,
   input wire        sys_rst,
   // bus pins and protect
   input wire        sclIn,
   input wire        sdaOut,
   input wire        sdaOe,
   input wire        writeProtect,
   // write cycle and array ports
   input wire        writeBusy,
   input wire [16:0] memRdAddr,
   input wire        memWrValid,
   input wire        memWrReady,
   input wire [16:0] memWrAddr,
   input wire [7:0]  memWrData
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // ==========================================================
   // helper: last word taken, forgotten once the cycle is over
   reg [16:0] lastAddr_q;
   reg        haveLast_q;
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         lastAddr_q <= 17'h00000;
         haveLast_q <= 1'b0;
      end else if (memWrValid && memWrReady) begin
         lastAddr_q <= memWrAddr;
         haveLast_q <= 1'b1;
      end else if (!writeBusy) begin
         haveLast_q <= 1'b0;
      end
   end

   // ==========================================================
   // assertions
   AST_OPEN_DRAIN: assert property (sdaOut == 1'b0)
      else $error("sda data not low");
   AST_SDA_SCL_LOW: assert property ($changed(sdaOe) |-> !$past(sclIn))
      else $error("sda drive moved with clock high");
   AST_STREAM_START: assert property ($rose(writeBusy) |=> memWrValid)
      else $error("no stream after busy");
   AST_STREAM_IN_BUSY: assert property (memWrValid |-> writeBusy)
      else $error("word offered while idle");
   AST_FIRST_OFFSET: assert property (memWrValid && memWrReady
      && !haveLast_q |-> memWrAddr[6:0] == 7'h00)
      else $error("page stream not from offset zero");
   AST_PAGE_STEP: assert property (memWrValid && memWrReady
      && haveLast_q |->
      memWrAddr == {lastAddr_q[16:7], lastAddr_q[6:0] + 7'h01})
      else $error("stream left the page or skipped");
   AST_STALL_HOLD: assert property (memWrValid && !memWrReady |=>
      memWrValid && $stable(memWrAddr) && $stable(memWrData))
      else $error("stalled word changed");
   AST_READBACK_PAGE: assert property (memWrValid |->
      memRdAddr[16:7] == memWrAddr[16:7])
      else $error("readback outside page");
   AST_WP_SKIPS: assert property ($rose(writeBusy) |->
      !$past(writeProtect, 8))
      else $error("write cycle while protected");
   AST_BUSY_ENDS: assert property ($rose(writeBusy) |->
      ##[1:1000] !writeBusy)
      else $error("write cycle too long");
endmodule

// [testbench/sees_master_model.sv]
// behavioural two-wire bus master that drives the serial clock
`timescale 1ns/1ns

module sees_master_model (
   // clock and resolved data wire
   input wire clk_sys,
   input wire sdaIn,
   // bus drive
   output reg sclOut,
   output reg sdaLow
);
   // ==========================================================
   // bus idles with both lines released high
   initial begin
      sclOut = 1'b1;
      sdaLow = 1'b0;
   end

   // move only just after falling edges of the system clock
   task hp(input integer n);
      repeat (n) @(negedge clk_sys);
   endtask

   // 5 clk low then 3 high; data set mid low, read late high
   task bitIo(input b, output r);
      hp(2);
      sdaLow = !b;
      hp(3);
      sclOut = 1'b1;
      hp(2);
      r = sdaIn;
      hp(1);
      sclOut = 1'b0;
   endtask

   // releases data first, so it serves as a repeated start too
   task start;
      hp(2);
      sdaLow = 1'b0;
      hp(3);
      sclOut = 1'b1;
      hp(3);
      sdaLow = 1'b1;
      hp(3);
      sclOut = 1'b0;
   endtask

   // data rises while the clock is high, bus left idle
   task stop;
      hp(2);
      sdaLow = 1'b1;
      hp(3);
      sclOut = 1'b1;
      hp(3);
      sdaLow = 1'b0;
      hp(3);
   endtask

   // eight bits msb first plus the acknowledge clock
   task wrByte(input [7:0] d, output ack);
      reg r;
      for (integer i = 7; i >= 0; i--) bitIo(d[i], r);
      bitIo(1'b1, r);
      ack = !r;
   endtask

   // last byte of a read is left unacknowledged
   task rdByte(input more, output [7:0] d);
      reg r;
      for (integer i = 7; i >= 0; i--) bitIo(1'b1, d[i]);
      bitIo(!more, r);
   endtask
endmodule

// [testbench/sees_slave_tb_top.sv]
// self-checking bench for the eeprom slave front end
`timescale 1ns/1ns

module sees_slave_tb_top;
   // ==========================================================
   // design signals and model state
   reg         clk_sys;
   reg         sys_rst;
   reg         writeProtect;
   reg         memWrReady;
   reg  [7:0]  memRdData;
   reg         chipLo;
   reg         chipHi;
   wire        sclIn;
   wire        sdaLow;
   wire        sdaW;
   wire        sdaOut;
   wire        sdaOe;
   wire        writeBusy;
   wire        memWrValid;
   wire [16:0] memRdAddr;
   wire [16:0] memWrAddr;
   wire [7:0]  memWrData;
   logic [7:0] mem [int];
   logic [7:0] refm [int];
   logic [16:0] wa;
   logic       k;
   int         ptr;
   int         nWords;
   int         error_cnt;
   int         checks_done;
   localparam logic [7:0] BAD [3] = '{8'hB2, 8'hA4, 8'hA0};
   localparam logic [16:0] SEQ [2] = '{17'h0FFFE, 17'h1FFFF};

   sees_slave #(.TWC_CYCLES(18'h000C8)) dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .sclIn(sclIn),
      .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .chipSelPinLow(chipLo), .chipSelPinHigh(chipHi),
      .fixedSelectPin(1'b1), .writeProtect(writeProtect),
      .writeBusy(writeBusy), .memRdAddr(memRdAddr),
      .memRdData(memRdData), .memWrValid(memWrValid),
      .memWrReady(memWrReady), .memWrAddr(memWrAddr),
      .memWrData(memWrData));
   sees_master_model u_mst (.clk_sys(clk_sys), .sdaIn(sdaW),
      .sclOut(sclIn), .sdaLow(sdaLow));

   // open-drain wire with pull-up; array answers in the same cycle
   assign sdaW = (sdaOe ? sdaOut : 1'b1) & !sdaLow;
   always @(memRdAddr, nWords)
      memRdData = mem.exists(memRdAddr) ? mem[memRdAddr] : pat(memRdAddr);
   always #10 clk_sys = ~clk_sys;

   // unwritten array content is a fixed address pattern
   function automatic [7:0] pat(input int a);
      return a[7:0] ^ a[16:9];
   endfunction
   function automatic [7:0] refAt(input int a);
      return refm.exists(a) ? refm[a] : pat(a);
   endfunction

   task automatic chkVal(input string w, input logic [16:0] e,
                         input logic [16:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic chkBit(input string w, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s expected %b seen %b", w, e, g);
      end
   endtask

   // every programmed word must match the page the model expects
   always @(posedge clk_sys) begin
      if (memWrValid && memWrReady) begin
         chkVal("prog data", refAt(memWrAddr), memWrData);
         mem[memWrAddr] = memWrData;
         nWords++;
      end
   end

   // ==========================================================
   // bus command tasks
   task automatic ctl(input [7:0] c, input e);
      logic a;
      u_mst.wrByte(c, a);
      chkBit("ctrl ack", e, a);
   endtask
   task automatic setPtr(input [16:0] a);
      logic q;
      u_mst.start;
      ctl({4'hA, a[16], chipHi, chipLo, 1'b0}, 1'b1);
      u_mst.wrByte(a[15:8], q);
      chkBit("adrH ack", 1'b1, q);
      u_mst.wrByte(a[7:0], q);
      chkBit("adrL ack", 1'b1, q);
      ptr = a;
   endtask
   task automatic rd(input int n);
      logic [7:0] d;
      u_mst.start;
      ctl({4'hA, ptr[16], chipHi, chipLo, 1'b1}, 1'b1);
      for (int i = 0; i < n; i++) begin
         u_mst.rdByte(i < n - 1, d);
         chkVal("read data", refAt(ptr), d);
         ptr = {ptr[16], ptr[15:0] + 16'h0001};
      end
      u_mst.stop;
   endtask
   task automatic waitBusy(input logic v);
      for (int i = 0; i < 2000 && writeBusy !== v; i++) @(negedge clk_sys);
      chkBit("busy", v, writeBusy);
   endtask
   // page offsets wrap in 128; the poll during busy is refused
   task automatic wr(input [16:0] a, input int n);
      logic [7:0] d;
      logic       q;
      int         o;
      int         e;
      e = writeProtect ? 0 : 128;
      setPtr(a);
      o = a[6:0];
      for (int i = 0; i < n; i++) begin
         d = $urandom;
         u_mst.wrByte(d, q);
         chkBit("data ack", 1'b1, q);
         if (!writeProtect) refm[{a[16:7], o[6:0]}] = d;
         o = (o + 1) % 128;
      end
      ptr = {a[16:7], o[6:0]};
      nWords = 0;
      u_mst.stop;
      if (writeProtect) begin
         u_mst.hp(8);
         chkBit("busy", 1'b0, writeBusy);
      end else begin
         waitBusy(1'b1);
         writeProtect = 1'b1;
         u_mst.start;
         ctl({4'hA, a[16], chipHi, chipLo, 1'b0}, 1'b0);
         u_mst.stop;
         waitBusy(1'b0);
         writeProtect = 1'b0;
      end
      chkVal("words", e, nWords);
   endtask

   task report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // watchdog far beyond the expected run length
   initial begin
      #1000000;
      error_cnt++;
      $display("watchdog expired");
      report_and_stop;
   end

   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(32'h17010d8c));
      clk_sys = 1'b0;
      sys_rst = 1'b1;
      writeProtect = 1'b0;
      memWrReady = 1'b0;
      chipLo = 1'b1;
      chipHi = 1'b0;
      nWords = 0;
      error_cnt = 0;
      checks_done = 0;
      // random stalls by the array side
      fork
         forever begin
            @(negedge clk_sys);
            memWrReady = $urandom_range(1, 0);
         end
      join_none
      repeat (10) @(negedge clk_sys);
      sys_rst = 1'b0;
      u_mst.hp(5);
      foreach (BAD[i]) begin
         u_mst.start;
         ctl(BAD[i], 1'b0);
         u_mst.wrByte(8'hA2, k);
         chkBit("ignored", 1'b0, k);
         u_mst.stop;
      end
      $display("test refused done");
      wr(17'h1237E, 4);
      rd(1);
      setPtr(17'h12300);
      rd(2);
      $display("test page wrap done");
      repeat (2) begin
         wa = $urandom;
         wr(wa, 1);
         rd(1);
         setPtr(wa);
         rd(1);
      end
      $display("test byte write done");
      foreach (SEQ[i]) begin
         setPtr(SEQ[i]);
         rd(3);
      end
      $display("test sequential read done");
      // swap the chip address pins: the old select must now be refused
      chipHi = 1'b1;
      chipLo = 1'b0;
      u_mst.start;
      ctl(8'hA2, 1'b0);
      u_mst.stop;
      wr(17'h0A155, 2);
      setPtr(17'h0A155);
      rd(2);
      chipHi = 1'b0;
      chipLo = 1'b1;
      $display("test chip select done");
      writeProtect = 1'b1;
      wr(17'h00040, 2);
      writeProtect = 1'b0;
      setPtr(17'h00040);
      rd(2);
      $display("test protect done");
      report_and_stop;
   end
endmodule

bind sees_slave sees_slave_monitor u_mon (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .sclIn(sclIn),
   .sdaOut(sdaOut), .sdaOe(sdaOe), .writeProtect(writeProtect),
   .writeBusy(writeBusy), .memRdAddr(memRdAddr),
   .memWrValid(memWrValid), .memWrReady(memWrReady),
   .memWrAddr(memWrAddr), .memWrData(memWrData));
